/* File: hw/flash_bus_cycle.sv */
// One asynchronous word read or write cycle on the card pins.
// Assumes start is a one-cycle pulse issued only while idle.
`timescale 1ns/1ps
`include "flash_seq_consts.svh"
module flash_bus_cycle (
  input  wire logic                    pclk,     // 100 MHz clock
  input  wire logic                    presetn,  // Async reset, low
  input  wire logic                    start,    // Begin a cycle
  input  wire logic                    wr,       // 1 write, 0 read
  input  wire logic [20:0]             addr,     // Word address
  input  wire logic [15:0]             wdata,    // Write word
  output logic                         done,     // Cycle finished pulse
  output logic [15:0]                  rdata,    // Read word
  output logic                         ce_l_n,   // Low lane select
  output logic                         ce_h_n,   // High lane select
  output logic                         oe_n,     // Output enable
  output logic                         we_n,     // Write enable
  output logic [20:0]                  fl_addr,  // Card address
  output logic [15:0]                  dq_out,   // Data driven
  output logic                         dq_oe,    // Drive data bus
  input  wire logic [15:0]             dq_in     // Data from card
);
  import flash_seq_pkg::*;

  cyc_s r;
  cyc_s n;

  // Cycle walk: select, strobe, release strobe, deselect, recover
  always_comb begin
    n = r;
    n.done = 1'b0;
    case (r.st)
      B_IDLE: if (start) begin
        n.ce_n  = 1'b0;
        n.wr    = wr;
        n.addr  = addr;
        n.dout  = wdata;
        n.dq_oe = wr;
        n.cnt   = 4'(`SETUP_CYC - 1);
        n.st    = B_SETUP;
      end
      B_SETUP: if (r.cnt == 4'h0) begin
        n.we_n = !r.wr;
        n.oe_n = r.wr;
        n.cnt  = 4'(`STROBE_CYC - 1);
        n.st   = B_STROBE;
      end else begin
        n.cnt = r.cnt - 4'h1;
      end
      B_STROBE: if (r.cnt == 4'h0) begin
        // Data stays driven past the rising write edge
        n.we_n = 1'b1;
        n.oe_n = 1'b1;
        if (!r.wr) begin
          n.rdata = dq_in;
        end
        n.st = B_HOLD;
      end else begin
        n.cnt = r.cnt - 4'h1;
      end
      B_HOLD: begin
        // Both selects high so the next read relatches status
        n.ce_n  = 1'b1;
        n.dq_oe = 1'b0;
        n.cnt   = 4'(`RECOVER_CYC - 1);
        n.st    = B_RECOVER;
      end
      B_RECOVER: if (r.cnt == 4'h0) begin
        n.done = 1'b1;
        n.st   = B_IDLE;
      end else begin
        n.cnt = r.cnt - 4'h1;
      end
      default: n.st = B_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: B_IDLE, cnt: 4'h0, wr: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
             dq_oe: 1'b0, addr: `RST_ADDR, dout: `RST_WDATA, rdata: `RST_WDATA,
             done: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign done    = r.done;
  assign rdata   = r.rdata;
  assign ce_l_n  = r.ce_n;
  assign ce_h_n  = r.ce_n;
  assign oe_n    = r.oe_n;
  assign we_n    = r.we_n;
  assign fl_addr = r.addr;
  assign dq_out  = r.dout;
  assign dq_oe   = r.dq_oe;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strobe_excl_a: assert property (!(!r.oe_n && !r.we_n))
    else $error("read and write strobes both low");
  we_width_a: assert property ($fell(r.we_n) |-> (!r.we_n)[*6] ##1 r.we_n)
    else $error("write strobe width wrong");
  data_hold_a: assert property ($rose(r.we_n) |-> r.dq_oe && $stable(r.dout))
    else $error("data not held at write edge");
  read_release_a: assert property ($rose(r.oe_n) |=> r.ce_n ##1 r.ce_n)
    else $error("select not released after read");
  oe_selected_a: assert property (!r.oe_n |-> !r.ce_n && !r.dq_oe)
    else $error("read strobe without select or with drive");
  done_pulse_a: assert property (r.done |=> !r.done && r.ce_n)
    else $error("done longer than one cycle");

endmodule // flash_bus_cycle

/* File: hw/flash_cmd_host.sv */
// APB-controlled host that sequences commands to a two-lane word flash card.
// Assumes the card answers on plain async strobes; software polls busy.
//
// How it works
// - Latch on first strobe fall; release between.
// - Host checks both lane status bytes.
// - Supply flag set: clear before program operations.
// - Erase by setup then confirm, block address.
// - Word write: setup word, then address and data.
// - After suspend, read status and poll flags.
// - Lock by setup then confirm; failure flagged.
// - Erase, confirm, suspend, resume command words fixed.
// - Read status and lock command words fixed.
// - Lower status bits invalid while busy.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "flash_seq_consts.svh"
module flash_cmd_host (
  input  wire logic                    pclk,       // 100 MHz clock
  input  wire logic                    presetn,    // Async reset, low
  input  wire logic                    psel,       // APB select
  input  wire logic                    penable,    // APB access phase
  input  wire logic                    pwrite,     // APB write
  input  wire logic [11:0]             paddr,      // APB byte address
  input  wire logic [31:0]             pwdata,     // APB write data
  output logic [31:0]                  prdata,     // APB read data
  output logic                         pready,     // APB ready
  output logic                         pslverr,    // APB error
  output logic                         fl_reset_n, // Card reset, low
  output logic                         ce_l_n,     // Low lane select
  output logic                         ce_h_n,     // High lane select
  output logic                         oe_n,       // Output enable
  output logic                         we_n,       // Write enable
  output logic [20:0]                  fl_addr,    // Card address
  output logic [15:0]                  dq_out,     // Data driven
  output logic                         dq_oe,      // Drive data bus
  input  wire logic [15:0]             dq_in       // Data from card
);
  import flash_seq_pkg::*;

  host_s       r;
  host_s       n;
  logic        cyc_done;
  logic [15:0] cyc_rdata;

  // First command word of each operation
  function automatic logic [15:0] first_cmd(input op_e op);
    case (op)
      OP_CLEAR:      first_cmd = `CMD_CLEAR_STATUS;
      OP_ERASE:      first_cmd = `CMD_ERASE_SETUP;
      OP_WRITE:      first_cmd = `CMD_WRITE_SETUP;
      OP_LOCK:       first_cmd = `CMD_LOCK_SETUP;
      OP_SUSPEND:    first_cmd = `CMD_SUSPEND;
      OP_RESUME:     first_cmd = `CMD_CONFIRM;
      OP_READ_ARRAY: first_cmd = `CMD_READ_ARRAY;
      default:       first_cmd = `CMD_READ_STATUS;
    endcase
  endfunction

  // A status bit set in either lane
  function automatic logic lane_any(input logic [15:0] w, input int b);
    lane_any = w[b] | w[b + `LANE_SHIFT];
  endfunction

  // Ready needs both lanes, since each runs its own machine
  function automatic logic both_ready(input logic [15:0] w);
    both_ready = w[`SR_READY] & w[`SR_READY + `LANE_SHIFT];
  endfunction

  function automatic logic is_program(input op_e op);
    is_program = (op == OP_ERASE) || (op == OP_WRITE) || (op == OP_LOCK);
  endfunction

  // APB slave then command sequencer; one struct carries all state
  always_comb begin
    n = r;
    n.start   = 1'b0;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    // First access cycle: answer; second: commit at the sampling edge
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0;
      case (paddr)
        `OFS_CTRL:  n.prdata = {23'h0, r.card_run, 4'h0, r.op};
        `OFS_ADDR:  n.prdata = {11'h0, r.addr};
        `OFS_WDATA: n.prdata = {16'h0, r.wdata};
        `OFS_STAT:  n.prdata = {r.status, 12'h0, r.lane_err, r.refused, r.need_clear, r.busy};
        `OFS_RDATA: n.prdata = {16'h0, r.rword};
        default:    n.pslverr = 1'b1;
      endcase
    end else if (psel && penable && r.pready && pwrite) begin
      case (paddr)
        `OFS_CTRL: begin
          n.card_run = pwdata[`CTRL_RUN_BIT];
          if (op_e'(pwdata[3:0]) != OP_NONE) begin
            if (r.busy) begin
              n.refused = 1'b1;
            end else begin
              n.op      = op_e'(pwdata[3:0]);
              n.busy    = 1'b1;
              n.refused = 1'b0;
            end
          end
        end
        // Address and data are frozen while a sequence runs
        `OFS_ADDR:  if (r.busy) n.refused = 1'b1; else n.addr = pwdata[20:0];
        `OFS_WDATA: if (r.busy) n.refused = 1'b1; else n.wdata = pwdata[15:0];
        default: ;
      endcase
    end

    // Sequencer: command cycles carry the same byte to both lanes; the write data cycle carries wdata
    case (r.st)
      S_IDLE: if (r.busy) begin
        if (r.need_clear && is_program(r.op)) begin
          n.refused = 1'b1;
          n.busy    = 1'b0;
        end else begin
          n.start = 1'b1;
          n.wr    = 1'b1;
          n.cdata = first_cmd(r.op);
          n.poll  = (r.op != OP_CLEAR) && (r.op != OP_READ_STATUS)
                    && (r.op != OP_READ_ARRAY);
          n.st    = S_W1;
        end
      end
      S_W1: if (cyc_done) begin
        n.start = 1'b1;
        case (r.op)
          OP_ERASE: begin
            n.cdata = `CMD_CONFIRM;
            n.st    = S_W2;
          end
          OP_WRITE: begin
            n.cdata = r.wdata;
            n.st    = S_W2;
          end
          OP_LOCK: begin
            n.cdata = `CMD_LOCK_CONFIRM;
            n.st    = S_W2;
          end
          OP_SUSPEND: begin
            // Suspend leaves the prior mode; ask for status explicitly
            n.cdata = `CMD_READ_STATUS;
            n.st    = S_W2;
          end
          OP_CLEAR: begin
            n.start      = 1'b0;
            n.need_clear = 1'b0;
            n.lane_err   = 1'b0;
            n.busy       = 1'b0;
            n.st         = S_IDLE;
          end
          default: begin
            n.wr = 1'b0;
            n.st = S_POLL;
          end
        endcase
      end
      S_W2: if (cyc_done) begin
        n.start = 1'b1;
        n.wr    = 1'b0;
        n.st    = S_POLL;
      end
      S_POLL: if (cyc_done) begin
        // Low status bits mean nothing until both lanes are ready
        if (r.poll && !both_ready(cyc_rdata)) begin
          n.start = 1'b1;
        end else begin
          n.busy = 1'b0;
          n.st   = S_IDLE;
          if (r.op == OP_READ_ARRAY) begin
            n.rword = cyc_rdata;
          end else begin
            n.status = cyc_rdata;
            n.need_clear = r.need_clear | lane_any(cyc_rdata, `SR_SUPPLY);
            n.lane_err = lane_any(cyc_rdata, `SR_EERR) | lane_any(cyc_rdata, `SR_WERR)
                         | lane_any(cyc_rdata, `SR_LOCK);
          end
        end
      end
      default: n.st = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: S_IDLE, op: OP_NONE, poll: 1'b0, addr: `RST_ADDR, wdata: `RST_WDATA,
             status: `RST_STATUS, rword: `RST_WDATA, busy: 1'b0, need_clear: 1'b0,
             refused: 1'b0, lane_err: 1'b0, card_run: 1'b0, start: 1'b0, wr: 1'b0,
             cdata: `RST_WDATA, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0};
    end else begin
      r <= n;
    end
  end

  // Pin cycle engine
  flash_bus_cycle u_cycle (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (r.start),
    .wr      (r.wr),
    .addr    (r.addr),
    .wdata   (r.cdata),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .ce_l_n  (ce_l_n),
    .ce_h_n  (ce_h_n),
    .oe_n    (oe_n),
    .we_n    (we_n),
    .fl_addr (fl_addr),
    .dq_out  (dq_out),
    .dq_oe   (dq_oe),
    .dq_in   (dq_in)
  );

  assign prdata     = r.prdata;
  assign pready     = r.pready;
  assign pslverr    = r.pslverr;
  assign fl_reset_n = r.card_run;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_answer_a: assert property (r.pready |-> $past(psel && penable) ##1 !r.pready)
    else $error("ready without access or held too long");
  refuse_prog_a: assert property (r.st == S_IDLE && r.busy && r.need_clear
                                  && is_program(r.op) |=> !r.busy && r.refused && !r.start)
    else $error("program operation not refused");
  erase_pair_a: assert property (r.st == S_IDLE && r.busy && !r.need_clear
                                 && r.op == OP_ERASE |=> r.cdata == 16'h2020 ##1 (!r.start) [*1])
    else $error("erase setup word wrong");
  erase_confirm_a: assert property (r.st == S_W1 && cyc_done && r.op == OP_ERASE
                                    |=> r.start && r.wr && r.cdata == 16'hd0d0)
    else $error("erase confirm word wrong");
  write_data_a: assert property (r.st == S_W1 && cyc_done && r.op == OP_WRITE
                                 |=> r.start && r.wr && r.cdata == r.wdata)
    else $error("write data cycle wrong");
  lock_confirm_a: assert property (r.st == S_W1 && cyc_done && r.op == OP_LOCK
                                   |=> r.cdata == 16'h0101 && r.st == S_W2)
    else $error("lock confirm word wrong");
  suspend_poll_a: assert property (r.st == S_W1 && cyc_done && r.op == OP_SUSPEND
                                   |=> r.cdata == 16'h7070)
    else $error("status not requested after suspend");
  poll_again_a: assert property (r.st == S_POLL && cyc_done && r.poll
                                 && !both_ready(cyc_rdata) |=> r.start && !r.wr && r.busy)
    else $error("poll ended before both lanes ready");
  poll_end_a: assert property (r.st == S_POLL && cyc_done && r.op != OP_READ_ARRAY
                               |=> r.st == S_IDLE && r.status == $past(cyc_rdata) || r.start)
    else $error("status word not captured");

endmodule // flash_cmd_host

/* File: hw/flash_seq_consts.svh */
// Offsets, command words, status bit positions and timing for the flash host.
// Assumes a 100 MHz pclk; included by the package user modules by bare name.
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH

// Own APB register offsets
`define OFS_CTRL          12'h000
`define OFS_ADDR          12'h004
`define OFS_WDATA         12'h008
`define OFS_STAT          12'h00c
`define OFS_RDATA         12'h010
`define CTRL_RUN_BIT      8

// Reset values
`define RST_ADDR          21'h000000
`define RST_WDATA         16'h0000
`define RST_STATUS        16'h0000

// Command words, same byte on both lanes
`define CMD_READ_ARRAY    16'hffff
`define CMD_READ_STATUS   16'h7070
`define CMD_CLEAR_STATUS  16'h5050
`define CMD_ERASE_SETUP   16'h2020
`define CMD_CONFIRM       16'hd0d0
`define CMD_WRITE_SETUP   16'h4040
`define CMD_SUSPEND       16'hb0b0
`define CMD_LOCK_SETUP    16'h6060
`define CMD_LOCK_CONFIRM  16'h0101

// Status bit positions within one lane; high lane adds LANE_SHIFT
`define SR_READY          7
`define SR_ESUSP          6
`define SR_EERR           5
`define SR_WERR           4
`define SR_SUPPLY         3
`define SR_WSUSP          2
`define SR_LOCK           1
`define LANE_SHIFT        8

// Strobe timing in ns and derived cycle counts, rounded up
`define CLK_NS            10
`define SETUP_NS          10
`define STROBE_NS         60
`define RECOVER_NS        30
`define SETUP_CYC         ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_CYC        ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOVER_CYC       ((`RECOVER_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* File: hw/flash_seq_pkg.sv */
// Types shared by the flash host sequencer and its bus cycle engine.
// Assumes the constants header is compiled alongside.
package flash_seq_pkg;

  typedef enum logic [3:0] {
    OP_NONE, OP_READ_STATUS, OP_CLEAR, OP_ERASE, OP_WRITE,
    OP_LOCK, OP_SUSPEND, OP_RESUME, OP_READ_ARRAY
  } op_e;

  typedef enum logic [2:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD, B_RECOVER} bus_state_e;

  typedef enum logic [2:0] {S_IDLE, S_W1, S_W2, S_POLL} seq_state_e;

  typedef struct packed {
    bus_state_e  st;
    logic [3:0]  cnt;
    logic        wr;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe;
    logic [20:0] addr;
    logic [15:0] dout;
    logic [15:0] rdata;
    logic        done;
  } cyc_s;

  typedef struct packed {
    seq_state_e  st;
    op_e         op;
    logic        poll;
    logic [20:0] addr;
    logic [15:0] wdata;
    logic [15:0] status;
    logic [15:0] rword;
    logic        busy;
    logic        need_clear;
    logic        refused;
    logic        lane_err;
    logic        card_run;
    logic        start;
    logic        wr;
    logic [15:0] cdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } host_s;

endpackage

/* File: sim/flash_card_model.sv */
// Behavioural two-lane word flash card answering the host's strobes.
// Assumes word accesses only; busy time is kept in ns, not clocks.
`timescale 1ns/1ps
module flash_card_model #(parameter int BUSY_NS = 1500) (
  input  wire logic        reset_n,    // Card reset, low
  input  wire logic        ce_l_n,     // Low lane select
  input  wire logic        ce_h_n,     // High lane select
  input  wire logic        oe_n,       // Output enable
  input  wire logic        we_n,       // Write enable
  input  wire logic [20:0] addr,       // Word address
  input  wire logic [15:0] dq_host,    // Host data
  input  wire logic        supply_low, // Force supply fault
  output logic      [15:0] dq_card     // Data seen by host
);
  logic [6:0]  sr [2];    // Status bits six to zero
  logic        rs [2];    // Status read mode
  logic [1:0]  pend [2];  // 1 erase, 2 write, 3 lock
  logic [15:0] mem [int];
  bit          lockd [int];
  logic [15:0] lat;
  logic        held;
  time         rdy_t;
  logic [7:0]  b;
  int          blk;
  logic        run;   // Busy when the strobe rose
  time         t0;    // Busy end, or now when idle
  time         left;  // Work left at suspend
  logic [1:0]  kind;  // 1 erase, 2 write, 3 lock

  // Reset leaves both lanes in array mode, status clean
  always @(negedge reset_n) begin
    rdy_t = 0;
    held = 0;
    left = 0;
    kind = 0;
    for (int l = 0; l < 2; l++) begin
      sr[l] = 0;
      rs[l] = 0;
      pend[l] = 0;
    end
  end

  // Each lane decodes its own byte on the rising strobe
  always @(posedge we_n) begin
    blk = addr[20:16];
    // Sample busy once so both lanes see the same suspend point
    run = $time < rdy_t;
    t0 = run ? rdy_t : $time;
    for (int l = 0; l < 2; l++) begin
      b = dq_host[8*l +: 8];
      if (!reset_n || (l ? ce_h_n : ce_l_n)) continue;
      if (pend[l] != 0) begin
        rs[l] = 1;
        if (supply_low)
          sr[l] |= 7'h08;
        else if (pend[l] == 2 && lockd.exists(blk))
          sr[l] |= 7'h12;
        else if (pend[l] == 2) begin
          if (!mem.exists(addr)) mem[addr] = 16'hffff;
          mem[addr][8*l +: 8] &= b;
          rdy_t = $time + BUSY_NS;
          kind = 2;                                      // Ready drops, erase flag kept
        end else if (pend[l] == 1 && b == 8'hd0 && lockd.exists(blk))
          sr[l] |= 7'h22;
        else if (pend[l] == 1 && b == 8'hd0) begin
          foreach (mem[k]) if (k[20:16] == blk) mem[k][8*l +: 8] = 8'hff;
          rdy_t = $time + BUSY_NS;
          kind = 1;
        end else if (pend[l] == 3 && b == 8'h01) begin
          lockd[blk] = 1;
          rdy_t = $time + BUSY_NS;
          kind = 3;
        end else
          sr[l] |= 7'h30;
        pend[l] = 0;
      end else if (sr[l][2] && !(b inside {8'hff, 8'h70, 8'hd0})) begin
        // Write suspended: anything else is ignored
      end else if (sr[l][6] && !(b inside {8'hff, 8'h70, 8'hd0, 8'h40, 8'h10})) begin
        // Erase suspended: no erase, lock or clear
      end else case (b)
        8'h20: pend[l] = 1;
        8'h40, 8'h10: pend[l] = 2;
        8'h60: pend[l] = 3;
        8'h70: rs[l] = 1;
        8'h50: sr[l] &= 7'h44;
        8'hff: rs[l] = 0;
        8'hb0: if (run && kind != 3) begin
          sr[l][kind == 2 ? 2 : 6] = 1;
          left = t0 - $time;
          rdy_t = $time;
        end
        // Resume waits for a write begun under suspend
        8'hd0: if (sr[l][2] || sr[l][6]) begin
          kind = sr[l][2] ? 2'd2 : 2'd1;
          sr[l][kind == 2 ? 2 : 6] = 0;
          rs[l] = 1;
          rdy_t = t0 + left;
        end
        default: ;
      endcase
    end
  end

  // Latch once on the first falling strobe; refresh needs a release
  always @(negedge oe_n or negedge ce_l_n) begin
    if (!held && reset_n) begin
      held = 1;
      lat = mem.exists(addr) ? mem[addr] : 16'hffff;
      for (int l = 0; l < 2; l++)
        if (rs[l] || $time < rdy_t) lat[8*l +: 8] = {$time >= rdy_t, sr[l]};
    end
  end
  always @(posedge oe_n or posedge ce_l_n) held = 0;

  // Released bus shows the inverse so a stale word never passes
  assign dq_card = (!oe_n && !ce_l_n) ? lat : ~lat;
endmodule // flash_card_model

/* File: sim/flash_cmd_host_tb.sv */
// Self-checking bench for the APB flash command host.
// Assumes the card model stands on the far side of the strobe pins.
`timescale 1ns/1ps
`include "flash_seq_consts.svh"
module flash_cmd_host_tb;
  logic        pclk = 0;
  logic        presetn;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, fl_reset_n, ce_l_n, ce_h_n, oe_n, we_n, dq_oe;
  logic [20:0] fl_addr;
  logic [15:0] dq_out, dq_in;
  logic        supply_low = 0;
  logic [15:0] wq [$];
  logic [20:0] aq [$];
  int          n_mismatch = 0;
  int          n_compared = 0;
  logic [31:0] q;
  logic        e;

  always #5 pclk = ~pclk;

  flash_cmd_host uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fl_reset_n(fl_reset_n), .ce_l_n(ce_l_n), .ce_h_n(ce_h_n),
    .oe_n(oe_n), .we_n(we_n), .fl_addr(fl_addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in));
  flash_card_model card (.reset_n(fl_reset_n), .ce_l_n(ce_l_n), .ce_h_n(ce_h_n),
    .oe_n(oe_n), .we_n(we_n), .addr(fl_addr), .dq_host(dq_oe ? dq_out : ~dq_out),
    .supply_low(supply_low), .dq_card(dq_in));

  // Command words and their addresses as they cross the pins
  always @(posedge we_n) begin
    if (presetn) begin
      wq.push_back(dq_out);
      aq.push_back(fl_addr);
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; the answer is taken at the ready edge only
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask

  // Poll busy under a bound; a hang ends the run
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(0, `OFS_STAT, 0);
      n++;
    end while (q[0] !== 1'b0 && n < 400);
    if (q[0] !== 1'b0) begin
      n_mismatch++;
      results();
    end
  endtask

  task automatic op(logic [3:0] code);
    wq.delete();
    aq.delete();
    apb(1, `OFS_CTRL, 32'h100 | 32'(code));
    idle();
  endtask

  // Quiet pins and zero registers after reset, unmapped access refused
  task automatic t_reset();
    check("card reset", fl_reset_n, 0);
    check("strobes", {ce_l_n, ce_h_n, oe_n, we_n, dq_oe}, 5'b11110);
    apb(0, `OFS_CTRL, 0);
    check("ctrl", q, 0);
    apb(0, `OFS_STAT, 0);
    check("stat", q, 0);
    apb(0, 12'h020, 0);
    check("unmapped err", e, 1);
    check("unmapped data", q, 0);
    apb(1, `OFS_CTRL, 32'h100);
    repeat (2) @(posedge pclk);
    #1;
    check("card run", fl_reset_n, 1);
  endtask

  task automatic t_status();
    op(1);
    check("read status cmd", wq[0], 16'h7070);
    check("status ready", q[31:16], 16'h8080);
  endtask

  // Write, overwrite that only clears bits, erase the block, read back
  task automatic t_write();
    apb(1, `OFS_ADDR, 32'h010005);
    apb(1, `OFS_WDATA, 32'h1234);
    op(4);
    check("write setup", wq[0], 16'h4040);
    check("write data", wq[1], 16'h1234);
    check("write addr", aq[1], 32'h010005);
    check("write status", q[31:16], 16'h8080);
    apb(1, `OFS_WDATA, 32'h00ff);
    op(4);
    op(8);
    apb(0, `OFS_RDATA, 0);
    check("and of words", q, 32'h0034);
    apb(1, `OFS_ADDR, 32'h010000);
    op(3);
    check("erase setup", wq[0], 16'h2020);
    check("erase confirm", wq[1], 16'hd0d0);
    check("erase block", aq[1], 32'h010000);
    apb(1, `OFS_ADDR, 32'h010005);
    op(8);
    apb(0, `OFS_RDATA, 0);
    check("erased word", q, 32'hffff);
  endtask

  // Order while busy is refused; a late suspend finds the erase done
  task automatic t_suspend();
    apb(1, `OFS_CTRL, 32'h103);
    apb(1, `OFS_CTRL, 32'h101);
    apb(0, `OFS_STAT, 0);
    check("refused", q[2], 1);
    idle();
    op(6);
    check("suspend cmd", wq[0], 16'hb0b0);
    check("then status", wq[1], 16'h7070);
    check("finished first", q[31:16], 16'h8080);
    op(7);
    check("resume cmd", wq[0], 16'hd0d0);
  endtask

  // Locked block rejects erase and write; errors stick until cleared
  task automatic t_lock();
    apb(1, `OFS_ADDR, 32'h020000);
    op(5);
    check("lock setup", wq[0], 16'h6060);
    check("lock confirm", wq[1], 16'h0101);
    check("lock block", aq[1], 32'h020000);
    op(3);
    check("locked erase", q[31:16], 16'ha2a2);
    check("lane err", q[3], 1);
    op(4);
    check("errors add up", q[31:16], 16'hb2b2);
    op(2);
    check("clear cmd", wq[0], 16'h5050);
    check("lane err gone", q[3], 0);
    op(1);
    check("clean status", q[31:16], 16'h8080);
  endtask

  // Supply fault blocks program orders until a clear
  task automatic t_supply();
    supply_low <= 1;
    apb(1, `OFS_ADDR, 32'h030000);
    op(4);
    check("supply flag", q[31:16], 16'h8888);
    check("need clear", q[1], 1);
    op(3);
    check("no card cycles", wq.size(), 0);
    check("refused", q[2], 1);
    supply_low <= 0;
    op(2);
    op(3);
    check("clear lifts", q[1], 0);
    check("erase runs", wq.size(), 2);
  endtask

  initial begin
    presetn = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    #1;
    t_reset();
    t_status();
    t_write();
    t_suspend();
    t_lock();
    t_supply();
    results();
  end
endmodule // flash_cmd_host_tb
